// File: core/asp_port.sv
// Purpose: Serial slave register port, clock mode 3, 3- or 4-wire
// Assumes: sclk from the master, stopped high while select is high
// Notes: Link logic on sclk, register file on clk_sys
`timescale 1ns/1ps
module asp_port (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic sclk, // Serial clock from the master
  input wire logic cs_n, // Chip select, active low
  input wire logic sdi_in, // Data input (shared line in three-wire)
  output logic sdi_out, // Shared line output, three-wire reads
  output logic sdi_oe_n, // Shared line enable, low while driving
  output logic sdo_out, // Data output, four-wire
  output logic sdo_oe_n, // Data output enable, low while driving
  output logic wr_strobe, // Register written, one-cycle pulse
  output logic [asp_pkg::ADDR_W-1:0] wr_addr, // Written register index
  output logic [asp_pkg::DATA_W-1:0] wr_data // Written value
);
  import asp_pkg::*;

  // ------------------------------------------------------------
  // Link side, clocked by sclk
  // ------------------------------------------------------------

  logic frame_rst_n; // Link reset: system reset or select high
  logic three_wire_l; // Wire-select bit seen on the link side
  logic three_wire_s; // Wire-select bit in the system domain
  logic [7:0] shift_in; // Byte including the bit now sampled

  // Select high ends the frame and clears all frame state
  assign frame_rst_n = rst_n & ~cs_n;

  // Link state
  logic [2:0] bit_cnt_reg, bit_cnt_next; // Bit within byte
  logic cmd_reg, cmd_next; // Still in command byte
  logic rd_reg, rd_next; // Transaction is a read
  logic mb_reg, mb_next; // multi_byte_flag
  logic done_reg, done_next; // First data byte finished
  logic [ADDR_W-1:0] ptr_reg, ptr_next; // Register pointer
  logic [6:0] shift_reg, shift_next; // Received bits so far

  // Request handed to the system domain
  logic req_tgl_reg, req_tgl_next; // Toggles once per request
  logic req_wr_reg, req_wr_next; // Request is a write
  logic [ADDR_W-1:0] req_addr_reg, req_addr_next; // Request index
  logic [DATA_W-1:0] req_data_reg, req_data_next; // Write data

  // Wire-select level into the link domain
  asp_sync u_wire_sync (
    .clk(sclk),
    .rst_n(rst_n),
    .d(three_wire_s),
    .q(three_wire_l)
  );

  assign shift_in = {shift_reg, sdi_in};

  // Rising-edge next state: bit count, command decode, pointer
  always_comb begin
    bit_cnt_next = bit_cnt_reg + 3'h1;
    cmd_next = cmd_reg;
    rd_next = rd_reg;
    mb_next = mb_reg;
    done_next = done_reg;
    ptr_next = ptr_reg;
    shift_next = shift_in[6:0];
    req_tgl_next = req_tgl_reg;
    req_wr_next = req_wr_reg;
    req_addr_next = req_addr_reg;
    req_data_next = req_data_reg;
    if (bit_cnt_reg == 3'h7) begin
      if (cmd_reg) begin
        // Command byte complete, MSB first
        cmd_next = 1'b0;
        rd_next = shift_in[CMD_RW_BIT];
        mb_next = shift_in[CMD_MB_BIT];
        ptr_next = shift_in[ADDR_W-1:0];
        if (shift_in[CMD_RW_BIT]) begin
          // Fetch the first read byte ahead of its first bit
          req_tgl_next = ~req_tgl_reg;
          req_wr_next = 1'b0;
          req_addr_next = shift_in[ADDR_W-1:0];
        end
      end else if (mb_reg || !done_reg) begin
        // Data byte complete; advance the pointer
        done_next = 1'b1;
        ptr_next = ptr_reg + 6'h01;
        req_tgl_next = ~req_tgl_reg;
        if (rd_reg) begin
          // Prefetch the next register for the next byte
          req_wr_next = 1'b0;
          req_addr_next = ptr_reg + 6'h01;
        end else begin
          // Hand the received byte over as a write
          req_wr_next = 1'b1;
          req_addr_next = ptr_reg;
          req_data_next = shift_in;
        end
      end
    end
  end

  // Frame registers, cleared whenever select is high
  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_reg <= 3'h0;
      cmd_reg <= 1'b1;
      rd_reg <= 1'b0;
      mb_reg <= 1'b0;
      done_reg <= 1'b0;
      ptr_reg <= 6'h00;
      shift_reg <= 7'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      cmd_reg <= cmd_next;
      rd_reg <= rd_next;
      mb_reg <= mb_next;
      done_reg <= done_next;
      ptr_reg <= ptr_next;
      shift_reg <= shift_next;
    end
  end

  // Request registers survive select so the toggle stays honest
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      req_tgl_reg <= 1'b0;
      req_wr_reg <= 1'b0;
      req_addr_reg <= 6'h00;
      req_data_reg <= 8'h00;
    end else begin
      req_tgl_reg <= req_tgl_next;
      req_wr_reg <= req_wr_next;
      req_addr_reg <= req_addr_next;
      req_data_reg <= req_data_next;
    end
  end

  // Falling-edge output shifter
  logic [DATA_W-1:0] rdata_reg; // Read byte held by the system side
  logic [DATA_W-1:0] out_sh_reg, out_sh_next; // Output shifter
  logic drive_reg, drive_next; // Output phase active
  logic byte_start; // First falling edge of a data byte

  assign byte_start = (bit_cnt_reg == 3'h0) && !cmd_reg;

  // Load a fresh byte at each byte start, else shift MSB first
  always_comb begin
    out_sh_next = {out_sh_reg[DATA_W-2:0], 1'b0};
    drive_next = drive_reg;
    if (byte_start) begin
      // rdata_reg is stable: written well before this edge
      out_sh_next = rdata_reg;
      // Drive only in the read data phase
      drive_next = rd_reg && (mb_reg || !done_reg);
    end
  end

  // Output registers, cleared whenever select is high
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_sh_reg <= 8'h00;
      drive_reg <= 1'b0;
    end else begin
      out_sh_reg <= out_sh_next;
      drive_reg <= drive_next;
    end
  end

  // Pin drivers; select rise releases both lines at once
  assign sdo_out = out_sh_reg[DATA_W-1];
  assign sdi_out = out_sh_reg[DATA_W-1];
  // Four-wire uses the output pin, three-wire the shared line
  assign sdo_oe_n = cs_n | ~drive_reg | three_wire_l;
  assign sdi_oe_n = cs_n | ~drive_reg | ~three_wire_l;
  // Idle select leaves both lines undriven; nothing starts here

  // ------------------------------------------------------------
  // System side, clocked by clk_sys
  // ------------------------------------------------------------

  logic req_tgl_s; // Synchronised request toggle
  logic cs_s; // Synchronised select
  logic [DATA_W-1:0] bank_rdata; // Register file read data

  asp_sync u_req_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d(req_tgl_reg),
    .q(req_tgl_s)
  );

  asp_sync u_cs_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d(cs_n),
    .q(cs_s)
  );

  // System state
  logic req_seen_reg, req_seen_next; // Last toggle taken
  logic cs_prev_reg, cs_prev_next; // Select one cycle ago
  logic [5:0] gap_cnt_reg, gap_cnt_next; // Select high time
  logic gap_short_reg, gap_short_next; // Gap too short, sticky
  logic [3:0] frame_cnt_reg, frame_cnt_next; // Frames seen
  logic [DATA_W-1:0] rdata_next; // Read byte next
  logic wr_strobe_reg, wr_strobe_next; // Write pulse
  logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next; // Write index
  logic [DATA_W-1:0] wr_data_reg, wr_data_next; // Write value
  logic req_new; // A new request has arrived
  logic bank_we; // Register file write
  logic [DATA_W-1:0] status; // Status register image

  // Request held steady for two clocks, safe to read now
  assign req_new = req_tgl_s ^ req_seen_reg;
  assign bank_we = req_new && req_wr_reg && (req_addr_reg != OFS_STATUS);
  assign status = {gap_short_reg, 3'h0, frame_cnt_reg};

  asp_regbank #(
    .AW(ADDR_W),
    .DW(DATA_W)
  ) u_bank (
    .clk(clk_sys),
    .rst_n(rst_n),
    .we(bank_we),
    .waddr(req_addr_reg),
    .wdata(req_data_reg),
    .raddr(req_addr_reg),
    .rdata(bank_rdata),
    .three_wire(three_wire_s)
  );

  // Serve requests, watch select gaps, keep status
  always_comb begin
    req_seen_next = req_tgl_s;
    cs_prev_next = cs_s;
    gap_cnt_next = gap_cnt_reg;
    gap_short_next = gap_short_reg;
    frame_cnt_next = frame_cnt_reg;
    rdata_next = rdata_reg;
    wr_strobe_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    if (req_new) begin
      if (req_wr_reg) begin
        wr_strobe_next = 1'b1;
        wr_addr_next = req_addr_reg;
        wr_data_next = req_data_reg;
        // Status write clears the gap flag
        if (req_addr_reg == OFS_STATUS) begin
          gap_short_next = 1'b0;
        end
      end else if (req_addr_reg == OFS_STATUS) begin
        rdata_next = status;
      end else begin
        rdata_next = bank_rdata;
      end
    end
    // Count select high time, saturating at the least gap
    if (cs_s) begin
      if (gap_cnt_reg < SELECT_IDLE_GAP_CYC) begin
        gap_cnt_next = gap_cnt_reg + 6'h01;
      end
    end else begin
      gap_cnt_next = 6'h00;
    end
    // Frame start: check the gap; a set beats a clear
    if (cs_prev_reg && !cs_s) begin
      frame_cnt_next = frame_cnt_reg + 4'h1;
      if (gap_cnt_reg < SELECT_IDLE_GAP_CYC) begin
        gap_short_next = 1'b1;
      end
    end
  end

  // System registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_seen_reg <= 1'b0;
      cs_prev_reg <= 1'b0;
      gap_cnt_reg <= SELECT_IDLE_GAP_CYC;
      gap_short_reg <= 1'b0;
      frame_cnt_reg <= 4'h0;
      rdata_reg <= 8'h00;
      wr_strobe_reg <= 1'b0;
      wr_addr_reg <= 6'h00;
      wr_data_reg <= 8'h00;
    end else begin
      req_seen_reg <= req_seen_next;
      cs_prev_reg <= cs_prev_next;
      gap_cnt_reg <= gap_cnt_next;
      gap_short_reg <= gap_short_next;
      frame_cnt_reg <= frame_cnt_next;
      rdata_reg <= rdata_next;
      wr_strobe_reg <= wr_strobe_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
    end
  end

  assign wr_strobe = wr_strobe_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = wr_data_reg;
endmodule : asp_port

// File: inc/asp_pkg.sv
// Purpose: Shared constants for the accelerometer serial slave port
// Assumes: 6-bit register index, 8-bit registers, 100 MHz system clock
// Notes: Timing figures kept in their own units, cycles derived here
package asp_pkg;
  // Register geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  // Register offsets (register index on the serial link)
  localparam logic [5:0] OFS_FORMAT = 6'h31; // output_format_control
  localparam logic [5:0] OFS_STATUS = 6'h3f; // port status, read side
  // Field positions
  localparam int FMT_WIRE_BIT = 6; // Set selects three-wire operation
  localparam int CMD_RW_BIT = 7; // First byte: one means read
  localparam int CMD_MB_BIT = 6; // First byte: multi_byte_flag
  localparam int STS_GAP_BIT = 7; // Status: idle gap found too short
  // Reset values
  localparam logic [7:0] FMT_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_MAX_KHZ = 5000; // Fastest serial clock
  localparam int SELECT_IDLE_GAP_NS = 250; // Least select high time
  localparam int OUTPUT_RELEASE_NS = 100; // Select rise to release
  localparam int OUTPUT_CHANGE_DELAY_NS = 95; // Falling edge to new bit
  // Least time, rounded up to whole cycles
  localparam logic [5:0] SELECT_IDLE_GAP_CYC =
    6'((SELECT_IDLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : asp_pkg

// File: core/asp_sync.sv
// Purpose: Two-flop level synchroniser
// Assumes: Input is a level, asynchronous to clk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module asp_sync (
  clk, // Destination clock
  rst_n, // Asynchronous reset, active low
  d, // Level from the other domain
  q // Synchronised level
);
  input wire logic clk; // Destination clock
  input wire logic rst_n; // Reset, active low
  input wire logic d; // Asynchronous level
  output logic q; // Synchronised level

  logic meta_reg; // First stage
  logic meta_next; // First stage next
  logic q_reg; // Second stage
  logic q_next; // Second stage next

  // Next values of the two stages
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  // Stage registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule : asp_sync

// File: core/asp_regbank.sv
// Purpose: Byte register file in flip-flops
// Assumes: One write port, one combinational read port
// Notes: Wire-select bit of the format register comes out as a separate field
`timescale 1ns/1ps
module asp_regbank #(
  parameter int AW = 6, // Index width
  parameter int DW = 8 // Register width
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic we, // Write strobe, one cycle
  input wire logic [AW-1:0] waddr, // Write index
  input wire logic [DW-1:0] wdata, // Write data
  input wire logic [AW-1:0] raddr, // Read index
  output logic [DW-1:0] rdata, // Read data
  output logic three_wire // Wire-select bit of the format register
);
  import asp_pkg::*;

  localparam int DEPTH = 1 << AW; // Number of registers

  logic [DW-1:0] mem_reg [DEPTH]; // Storage
  logic [DW-1:0] mem_next [DEPTH]; // Storage next

  // Write decode
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (we) begin
      mem_next[waddr] = wdata;
    end
  end

  // Storage registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= (i == int'(OFS_FORMAT)) ? FMT_RESET : REG_RESET;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

  assign rdata = mem_reg[raddr];
  assign three_wire = mem_reg[OFS_FORMAT][FMT_WIRE_BIT];
endmodule : asp_regbank

// File: verif/asp_port_checker.sv
// Purpose: Pin assertions for the serial slave port
// Assumes: Serial clock far slower than clk_sys
// Notes: Serial edges are seen by sampling on clk_sys
`timescale 1ns/1ps
module asp_port_checker (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic sclk, // Serial clock
  input wire logic cs_n, // Select, active low
  input wire logic sdi_in, // Data input
  input wire logic sdi_out, // Shared line data
  input wire logic sdi_oe_n, // Shared line enable, active low
  input wire logic sdo_out, // Output data
  input wire logic sdo_oe_n, // Output enable, active low
  input wire logic wr_strobe, // Write pulse
  input wire logic [asp_pkg::ADDR_W-1:0] wr_addr, // Written index
  input wire logic [asp_pkg::DATA_W-1:0] wr_data // Written value
);
  import asp_pkg::*;
  logic sclk_reg; // Serial clock one sample ago
  logic sclk_next; // Next sampled clock
  logic [3:0] edge_cnt_reg; // Rising edges in frame, saturating
  logic [3:0] edge_cnt_next; // Next edge count
  // Count rising serial edges while selected
  always_comb begin
    sclk_next = sclk;
    edge_cnt_next = edge_cnt_reg;
    if (cs_n) begin
      edge_cnt_next = 4'h0; // Frame over
    end else if (sclk && !sclk_reg && edge_cnt_reg != 4'hf) begin
      edge_cnt_next = edge_cnt_reg + 4'h1; // New rising edge
    end
  end
  // Register the counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_reg <= 1'b1;
      edge_cnt_reg <= 4'h0;
    end else begin
      sclk_reg <= sclk_next;
      edge_cnt_reg <= edge_cnt_next;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  release_a: assert property (cs_n |-> sdo_oe_n && sdi_oe_n)
    else $error("data line driven while deselected");
  one_line_a: assert property (sdo_oe_n || sdi_oe_n)
    else $error("both data lines driven");
  cmd_quiet_a:
    assert property (edge_cnt_reg < 4'h8 |-> sdo_oe_n && sdi_oe_n)
    else $error("line driven during command byte");
  four_start_a:
    assert property ($fell(sdo_oe_n) |-> $fell(sclk) && edge_cnt_reg == 4'h8)
    else $error("output drive starts at wrong edge");
  three_start_a:
    assert property ($fell(sdi_oe_n) |-> $fell(sclk) && edge_cnt_reg == 4'h8)
    else $error("shared line drive starts at wrong edge");
  shift_fall_a:
    assert property (!sdo_oe_n && $changed(sdo_out) |-> $fell(sclk))
    else $error("output bit changed off a falling edge");
  hold_rise_a:
    assert property (!sdi_oe_n && $rose(sclk) |-> $stable(sdi_out))
    else $error("shared line bit moved at rising edge");
  strobe_once_a: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  write_hold_a:
    assert property ($changed(wr_data) || $changed(wr_addr) |-> wr_strobe)
    else $error("write outputs moved without strobe");
  wr_seen_c: cover property (wr_strobe);
  four_read_c: cover property ($fell(sdo_oe_n));
  three_read_c: cover property ($fell(sdi_oe_n));
endmodule : asp_port_checker
bind asp_port asp_port_checker asp_port_checker_i (.clk_sys, .rst_n,
  .sclk, .cs_n, .sdi_in, .sdi_out, .sdi_oe_n, .sdo_out, .sdo_oe_n,
  .wr_strobe, .wr_addr, .wr_data);

// File: verif/asp_master.sv
// Purpose: Serial bus master model for the slave port
// Assumes: Mode 3 link clock of 160 ns, frames up to four bytes
// Notes: Data is released after the command byte of three-wire reads
`timescale 1ns/1ps
module asp_master (
  output logic sclk, // Serial clock, idles high
  output logic cs_n, // Select, active low
  output logic mosi, // Data toward the port
  output logic mosi_en, // High while this side drives data
  input wire logic miso // Data coming back
);
  // Idle lines always driven, clock stopped high
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b1;
    mosi_en = 1'b1;
  end
  // One framed transfer of n bytes, first byte the command
  task automatic frame(input logic [31:0] tx, input int n, input bit rel,
      input int gap, output logic [31:0] rx);
    rx = 32'h0;
    #(gap + 3.7);
    cs_n = 1'b0;
    #80;
    for (int i = 0; i < 8 * n; i++) begin
      sclk = 1'b0;
      mosi = tx[31 - i];
      mosi_en = !(rel && i >= 8);
      #80;
      rx[31 - i] = miso;
      sclk = 1'b1;
      #80;
    end
    // Quiet time: the last rising edge is taken before select rises
    #80;
    cs_n = 1'b1;
    mosi = 1'b1;
    mosi_en = 1'b1;
  endtask : frame
endmodule : asp_master

// File: verif/asp_port_tb_top.sv
// Purpose: Self-checking bench for the serial slave port
// Assumes: Master model runs the link at a 160 ns clock
// Notes: Writes seen on the wr side, reads on the data lines
`timescale 1ns/1ps
module asp_port_tb_top;
  import asp_pkg::*;
  logic clk_sys; // System clock
  logic rst_n; // Reset, active low
  logic sclk; // Serial clock
  logic cs_n; // Select
  logic mosi; // Master data
  logic mosi_en; // Master drives data
  logic sdi_in; // Resolved shared line
  logic sdi_out; // Port shared line data
  logic sdi_oe_n; // Port shared line enable
  logic sdo_out; // Port output data
  logic sdo_oe_n; // Port output enable
  logic wr_strobe; // Write pulse
  logic [ADDR_W-1:0] wr_addr; // Written index
  logic [DATA_W-1:0] wr_data; // Written value
  logic three_wire; // Wire mode the bench expects
  logic miso; // Line the master reads
  logic [13:0] wq[$]; // Seen writes, index then value
  int fail_count; // Mismatches
  int checks; // Comparisons
  // A released line shows the inverse of its last value
  assign sdi_in = !sdi_oe_n ? sdi_out : (mosi_en ? mosi : ~sdi_out);
  assign miso = three_wire ? sdi_in : (sdo_oe_n ? ~sdo_out : sdo_out);
  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Record every register write
  always @(posedge clk_sys) begin
    if (wr_strobe === 1'b1) begin
      wq.push_back({wr_addr, wr_data});
    end
  end
  asp_port asp_port_i (.clk_sys, .rst_n, .sclk, .cs_n, .sdi_in, .sdi_out,
    .sdi_oe_n, .sdo_out, .sdo_oe_n, .wr_strobe, .wr_addr, .wr_data);
  asp_master asp_master_i (.sclk, .cs_n, .mosi, .mosi_en, .miso);
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Report and end the run
  task automatic give_verdict;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  // Bounded wait for n recorded writes
  task automatic wait_wr(input int n);
    for (int i = 0; i < 40 && wq.size() < n; i++) begin
      @(negedge clk_sys);
    end
    check(32'(wq.size() >= n), 32'h1);
    if (wq.size() < n) begin
      give_verdict();
    end
  endtask : wait_wr
  // Reset keeps lines released and writes quiet
  task automatic t_reset;
    rst_n = 1'b0;
    repeat (16) @(negedge clk_sys);
    check(32'({sdo_oe_n, sdi_oe_n, wr_strobe}), 32'h6);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask : t_reset
  // Multi-byte write walks three registers
  task automatic t_burst_write;
    logic [31:0] rx;
    wq.delete();
    asp_master_i.frame(32'h50a55ac3, 4, 1'b0, 300, rx);
    wait_wr(3);
    check(32'(wq[0]), 32'h10a5);
    check(32'(wq[1]), 32'h115a);
    check(32'(wq[2]), 32'h12c3);
  endtask : t_burst_write
  // Without the flag, extra bytes are dropped
  task automatic t_single_write;
    logic [31:0] rx;
    wq.delete();
    asp_master_i.frame(32'h14778800, 3, 1'b0, 300, rx);
    wait_wr(1);
    repeat (20) @(negedge clk_sys);
    check(32'(wq.size()), 32'h1);
    check(32'(wq[0]), 32'h1477);
  endtask : t_single_write
  // Four-wire burst and single reads
  task automatic t_read4;
    logic [31:0] rx;
    asp_master_i.frame(32'hd0000000, 4, 1'b0, 300, rx);
    check(32'(rx[23:0]), 32'ha55ac3);
    asp_master_i.frame(32'h94000000, 2, 1'b0, 300, rx);
    check(32'(rx[23:16]), 32'h77);
  endtask : t_read4
  // Switch to three-wire, read and write there, then back
  task automatic t_three_wire;
    logic [31:0] rx;
    wq.delete();
    asp_master_i.frame(32'h31400000, 2, 1'b0, 300, rx);
    wait_wr(1);
    check(32'(wq[0]), 32'h3140);
    three_wire = 1'b1;
    asp_master_i.frame(32'hd0000000, 4, 1'b1, 300, rx);
    check(32'(rx[23:0]), 32'ha55ac3);
    asp_master_i.frame(32'h31000000, 2, 1'b0, 300, rx);
    wait_wr(2);
    check(32'(wq[1]), 32'h3100);
    three_wire = 1'b0;
    asp_master_i.frame(32'h94000000, 2, 1'b0, 300, rx);
    check(32'(rx[23:16]), 32'h77);
  endtask : t_three_wire
  // Short select gap is flagged in status, a write clears it
  task automatic t_gap;
    logic [31:0] rx;
    asp_master_i.frame(32'hbf000000, 2, 1'b0, 100, rx);
    check(32'(rx[23]), 32'h1);
    check(32'(rx[19:16]), 32'h9);
    wq.delete();
    asp_master_i.frame(32'h3f000000, 2, 1'b0, 300, rx);
    wait_wr(1);
    check(32'(wq[0]), 32'h3f00);
    asp_master_i.frame(32'hbf000000, 2, 1'b0, 300, rx);
    check(32'(rx[23]), 32'h0);
    check(32'(rx[19:16]), 32'hb);
  endtask : t_gap
  // Main sequence
  initial begin
    rst_n = 1'b0;
    three_wire = 1'b0;
    fail_count = 0;
    checks = 0;
    t_reset();
    t_burst_write();
    t_single_write();
    t_read4();
    t_three_wire();
    t_gap();
    give_verdict();
  end
endmodule : asp_port_tb_top
